// ### rtl/cesr_pkg.sv
// shared constants and enumerations of the configuration memory serial link
package cesr_pkg;

	// timing
	localparam int SYS_CLK_NS         = 25;
	localparam int LINK_PERIOD_MIN_NS = 10000;
	localparam int LINK_QUARTER_CYC   = (LINK_PERIOD_MIN_NS / 4 + SYS_CLK_NS - 1) / SYS_CLK_NS;

	// memory organisation
	localparam int               ADDR_W    = 24;
	localparam int               MEM_BYTES = 131072;
	localparam int               PAGE_W    = 7;
	localparam logic [PAGE_W-1:0] PAGE_ONE = 7'h01;
	localparam logic [23:0]      ID_ADDR   = 24'h040000;

	// device address byte, select bit last on the wire
	localparam logic [7:0] DEV_SELECT = 8'hA0;
	localparam logic [7:0] RW_READ    = 8'h01;

	// bit slots of one byte
	localparam logic [3:0] SLOT_LAST_BIT = 4'h7;
	localparam logic [3:0] SLOT_ACK      = 4'h8;

	// received byte kinds at the device
	localparam logic [2:0] K_DEV  = 3'h0;
	localparam logic [2:0] K_A2   = 3'h1;
	localparam logic [2:0] K_A1   = 3'h2;
	localparam logic [2:0] K_A0   = 3'h3;
	localparam logic [2:0] K_DATA = 3'h4;

	// programmer steps
	localparam logic [2:0] P_DEVW  = 3'h0;
	localparam logic [2:0] P_A2    = 3'h1;
	localparam logic [2:0] P_A1    = 3'h2;
	localparam logic [2:0] P_A0    = 3'h3;
	localparam logic [2:0] P_WDATA = 3'h4;
	localparam logic [2:0] P_DEVR  = 3'h5;
	localparam logic [2:0] P_RDATA = 3'h6;

	// synchroniser lanes and reset values
	localparam int         SY_SCL    = 0;
	localparam int         SY_SDA    = 1;
	localparam int         SY_ENN    = 2;
	localparam logic       SYNC_RST  = 1'b1;
	localparam logic [1:0] BOOT_WAIT = 2'h2;

	typedef enum logic [4:0] {
		DV_IDLE = 5'h01,
		DV_RX   = 5'h02,
		DV_ACKO = 5'h04,
		DV_TX   = 5'h08,
		DV_ACKI = 5'h10
	} cesr_dev_state_t;

	typedef enum logic [3:0] {
		PG_IDLE  = 4'h1,
		PG_START = 4'h2,
		PG_BYTE  = 4'h4,
		PG_STOP  = 4'h8
	} cesr_prg_state_t;

endpackage

// ### rtl/cesr_link_if.sv
// two-wire programming link between programmer and configuration memory
`timescale 1ns/1ps
interface cesr_link_if;
	logic cfg_serial_clock;
	logic program_mode_enable_n;
	logic cfg_serial_data;
	logic cfg_serial_data_dev_out;
	logic cfg_serial_data_dev_oe;
	logic cfg_serial_data_host_out;
	logic cfg_serial_data_host_oe;

	// open drain wire with pull-up
	assign cfg_serial_data = (cfg_serial_data_dev_oe ? cfg_serial_data_dev_out : 1'b1)
		& (cfg_serial_data_host_oe ? cfg_serial_data_host_out : 1'b1);

	modport device (
		input  cfg_serial_clock,
		input  program_mode_enable_n,
		input  cfg_serial_data,
		output cfg_serial_data_dev_out,
		output cfg_serial_data_dev_oe
	);

	modport programmer (
		output cfg_serial_clock,
		output program_mode_enable_n,
		input  cfg_serial_data,
		output cfg_serial_data_host_out,
		output cfg_serial_data_host_oe
	);
endinterface

// ### rtl/cesr_sync.sv
// two flip-flop synchroniser with edge pulses
`timescale 1ns/1ps
module cesr_sync (
	// system
	input  wire logic sys_clk,
	input  wire logic rst,
	// pin side
	input  wire logic async_in,
	// clock domain side
	output logic      level,
	output logic      rise,
	output logic      fall
);

	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} cesr_sync_reg_t;

	cesr_sync_reg_t s;
	cesr_sync_reg_t next_s;

	always_comb
	begin
		next_s.meta   = async_in;
		next_s.stable = s.meta;
		next_s.prev   = s.stable;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s <= '{meta: cesr_pkg::SYNC_RST, stable: cesr_pkg::SYNC_RST, prev: cesr_pkg::SYNC_RST};
		else
			s <= next_s;
	end

	// only the stable stage and its delayed copy are looked at
	assign level = s.stable;
	assign rise  = s.stable & ~s.prev;
	assign fall  = ~s.stable & s.prev;

endmodule // cesr_sync

// ### rtl/cesr_device.sv
// configuration memory end of the two-wire programming link
// Operation
// - read begins like write, select bit high
// - address counter holds last access plus one
// - counter kept while programming mode stays on
// - write ending page end moves to next page
// - current read sends byte at counter after ack
// - programmer stops after single byte to end
// - random read loads address by aborted write
// - random read byte sequence with acknowledges
// - address advances after each byte, host ack sends next
// - host ends sequential read with nack, stop
// - ack after top address wraps to zero
// - identification bytes read at code address
// - identification bytes go out LSB first
// - programmer writes whole pages, any order
// - boot copy of first byte needs power cycle
// - programmer verifies by reading every byte
// - link served only while enable held low
// - programmer holds FPGA in reset via enable
// - addresses MSB first, data bytes LSB first
// - any start returns to device address wait
`timescale 1ns/1ps
module cesr_device #(
	parameter int         MEM_BYTES  = cesr_pkg::MEM_BYTES,
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE  = 8'hC3  // arbitrary value
) (
	// system
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// link
	cesr_link_if.device     link,
	// user side
	output logic [7:0]      boot_first_byte,
	output logic            prog_mode_active
);

	localparam int MEM_AW = $clog2(MEM_BYTES);

	typedef struct packed {
		cesr_pkg::cesr_dev_state_t st;
		logic [2:0]                kind;
		logic [3:0]                bits;
		logic [7:0]                sh;
		logic                      read_op;
		logic [23:0]               addr;
		logic [23:0]               last_wr;
		logic                      wrote;
		logic                      drive_low;
		logic                      host_ack;
		logic [1:0]                boot_cnt;
		logic [7:0]                boot_byte;
	} cesr_dev_reg_t;

	localparam cesr_dev_reg_t DEV_RST = '{
		st:       cesr_pkg::DV_IDLE,
		kind:     cesr_pkg::K_DEV,
		bits:     4'h0,
		sh:       8'h00,
		read_op:  1'b0,
		addr:     24'h000000,
		last_wr:  24'h000000,
		wrote:    1'b0,
		drive_low: 1'b0,
		host_ack: 1'b0,
		boot_cnt: cesr_pkg::BOOT_WAIT,
		boot_byte: 8'h00
	};

	cesr_dev_reg_t s;
	cesr_dev_reg_t next_s;

	////////////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = v[7-i];
		return r;
	endfunction

	function automatic logic in_mem(input logic [23:0] a);
		return (a >> MEM_AW) == 24'h000000;
	endfunction

	function automatic logic [23:0] incr_lin(input logic [23:0] a);
		if (in_mem(a) && a == 24'(MEM_BYTES - 1))
			return 24'h000000;
		return a + 24'h000001;
	endfunction

	function automatic logic [23:0] incr_page(input logic [23:0] a);
		return {a[23:cesr_pkg::PAGE_W], a[cesr_pkg::PAGE_W-1:0] + cesr_pkg::PAGE_ONE};
	endfunction

	function automatic logic [7:0] read_byte(input logic [23:0] a, input logic [7:0] q);
		if (in_mem(a))
			return q;
		if (a[23:1] == cesr_pkg::ID_ADDR[23:1])
			return a[0] ? PART_CODE : MAKER_CODE;
		return 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] raw;
	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;

	assign raw[cesr_pkg::SY_SCL] = link.cfg_serial_clock;
	assign raw[cesr_pkg::SY_SDA] = link.cfg_serial_data;
	assign raw[cesr_pkg::SY_ENN] = link.program_mode_enable_n;

	for (genvar i = 0; i < 3; i++)
	begin : g_sync
		cesr_sync u_sync (
			.sys_clk  (sys_clk),
			.rst      (rst),
			.async_in (raw[i]),
			.level    (lvl[i]),
			.rise     (rise[i]),
			.fall     (fall[i])
		);
	end

	logic active;
	logic scl_rise;
	logic scl_fall;
	logic sda;
	logic start_ev;
	logic stop_ev;

	assign active   = ~lvl[cesr_pkg::SY_ENN];
	assign scl_rise = rise[cesr_pkg::SY_SCL];
	assign scl_fall = fall[cesr_pkg::SY_SCL];
	assign sda      = lvl[cesr_pkg::SY_SDA];
	assign start_ev = lvl[cesr_pkg::SY_SCL] & fall[cesr_pkg::SY_SDA];
	assign stop_ev  = lvl[cesr_pkg::SY_SCL] & rise[cesr_pkg::SY_SDA];

	////////////////////////////////////////////////////////////////////////////////////////
	// array

	logic [7:0]        mem [MEM_BYTES];
	logic [7:0]        mem_q;
	logic              mem_we;
	logic [MEM_AW-1:0] mem_wa;
	logic [7:0]        mem_wd;
	logic [MEM_AW-1:0] mem_ra;

	// boot copy reads location zero first, then follows the counter
	assign mem_ra = (s.boot_cnt != 2'h0) ? '0 : s.addr[MEM_AW-1:0];

	always_ff @(posedge sys_clk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		mem_q <= mem[mem_ra];
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// protocol engine

	logic [7:0] cur_byte;
	assign cur_byte = read_byte(s.addr, mem_q);

	always_comb
	begin
		next_s = s;
		mem_we = 1'b0;
		mem_wa = s.addr[MEM_AW-1:0];
		mem_wd = rev8(s.sh);
		// copy taken only once after reset, later writes stay invisible
		if (s.boot_cnt != 2'h0)
		begin
			next_s.boot_cnt = s.boot_cnt - 2'h1;
			if (s.boot_cnt == 2'h1)
				next_s.boot_byte = mem_q;
		end
		if (!active)
		begin
			next_s.st        = cesr_pkg::DV_IDLE;
			next_s.drive_low = 1'b0;
			next_s.addr      = 24'h000000;
			next_s.wrote     = 1'b0;
			next_s.bits      = 4'h0;
		end
		else if (start_ev || stop_ev)
		begin
			next_s.st        = start_ev ? cesr_pkg::DV_RX : cesr_pkg::DV_IDLE;
			next_s.kind      = cesr_pkg::K_DEV;
			next_s.bits      = 4'h0;
			next_s.drive_low = 1'b0;
			if (s.wrote)
			begin
				next_s.addr  = incr_lin(s.last_wr);
				next_s.wrote = 1'b0;
			end
		end
		else
		begin
			case (s.st)
				cesr_pkg::DV_IDLE:
				begin
					next_s.drive_low = 1'b0; // counter left alone here
				end
				cesr_pkg::DV_RX:
				begin
					if (scl_rise)
					begin
						next_s.sh   = {s.sh[6:0], sda};
						next_s.bits = s.bits + 4'h1;
					end
					else if (scl_fall && s.bits == cesr_pkg::SLOT_ACK)
					begin
						next_s.bits      = 4'h0;
						next_s.drive_low = 1'b1;
						next_s.st        = cesr_pkg::DV_ACKO;
						case (s.kind)
							cesr_pkg::K_DEV: next_s.read_op = s.sh[0];
							cesr_pkg::K_A2:  next_s.addr[23:16] = s.sh;
							cesr_pkg::K_A1:  next_s.addr[15:8] = s.sh;
							cesr_pkg::K_A0:  next_s.addr[7:0] = s.sh;
							default:
							begin
								mem_we         = in_mem(s.addr);
								next_s.last_wr = s.addr;
								next_s.addr    = incr_page(s.addr);
								next_s.wrote   = 1'b1;
							end
						endcase
					end
				end
				cesr_pkg::DV_ACKO:
				begin
					if (scl_fall)
					begin
						next_s.drive_low = 1'b0;
						next_s.st        = cesr_pkg::DV_RX;
						case (s.kind)
							cesr_pkg::K_DEV:
							begin
								next_s.kind = cesr_pkg::K_A2;
								if (s.read_op)
								begin
									next_s.st        = cesr_pkg::DV_TX;
									next_s.sh        = cur_byte;
									next_s.drive_low = ~cur_byte[0];
								end
							end
							cesr_pkg::K_A2: next_s.kind = cesr_pkg::K_A1;
							cesr_pkg::K_A1: next_s.kind = cesr_pkg::K_A0;
							default:        next_s.kind = cesr_pkg::K_DATA;
						endcase
					end
				end
				cesr_pkg::DV_TX:
				begin
					if (scl_fall)
					begin
						next_s.bits = s.bits + 4'h1;
						if (s.bits == cesr_pkg::SLOT_LAST_BIT)
						begin
							next_s.st        = cesr_pkg::DV_ACKI;
							next_s.drive_low = 1'b0;
							next_s.addr      = incr_lin(s.addr);
						end
						else
						begin
							next_s.sh        = {1'b0, s.sh[7:1]};
							next_s.drive_low = ~s.sh[1];
						end
					end
				end
				cesr_pkg::DV_ACKI:
				begin
					if (scl_rise)
						next_s.host_ack = ~sda;
					else if (scl_fall)
					begin
						next_s.bits = 4'h0;
						if (s.host_ack)
						begin
							next_s.st        = cesr_pkg::DV_TX;
							next_s.sh        = cur_byte;
							next_s.drive_low = ~cur_byte[0];
						end
						else
							next_s.st = cesr_pkg::DV_IDLE;
					end
				end
				default:
				begin
					next_s.st        = cesr_pkg::DV_IDLE;
					next_s.drive_low = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s <= DEV_RST;
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign link.cfg_serial_data_dev_out = 1'b0;
	assign link.cfg_serial_data_dev_oe  = s.drive_low;
	assign boot_first_byte              = s.boot_byte;
	assign prog_mode_active             = active;

endmodule // cesr_device

// ### rtl/cesr_programmer.sv
// programmer end of the two-wire link: makes the clock and runs reads and page writes
`timescale 1ns/1ps
module cesr_programmer #(
	parameter int QUARTER_CYC = cesr_pkg::LINK_QUARTER_CYC,
	parameter int LEN_W       = 18
) (
	// system
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// link
	cesr_link_if.programmer        link,
	// request
	input  wire logic              prog_mode,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic [23:0]       req_addr,
	input  wire logic [LEN_W-1:0]  req_len,
	// write data
	input  wire logic [7:0]        wr_data,
	output logic                   wr_take,
	// read data and status
	output logic [7:0]             rd_data,
	output logic                   rd_valid,
	output logic                   done,
	output logic                   nack
);

	typedef struct packed {
		cesr_pkg::cesr_prg_state_t st;
		logic [2:0]                step;
		logic                      tx;
		logic [1:0]                phase;
		logic [15:0]               qcnt;
		logic [3:0]                bitn;
		logic [7:0]                sh;
		logic                      rx_ack;
		logic [LEN_W-1:0]          remain;
		logic                      write_op;
		logic [23:0]               addr;
		logic                      scl;
		logic                      sda_low;
		logic                      en_n;
		logic                      wr_take;
		logic [7:0]                rd_data;
		logic                      rd_valid;
		logic                      done;
		logic                      nack;
	} cesr_prg_reg_t;

	localparam cesr_prg_reg_t PRG_RST = '{st: cesr_pkg::PG_IDLE, scl: 1'b1, en_n: 1'b1, default: '0};
	localparam logic [15:0]   Q_LAST  = 16'(QUARTER_CYC - 1);

	cesr_prg_reg_t s;
	cesr_prg_reg_t next_s;
	logic          sda;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = v[7-i];
		return r;
	endfunction

	cesr_sync u_sda_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (link.cfg_serial_data),
		.level    (sda),
		.rise     (),
		.fall     ()
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// sequencer, one phase is a quarter of a link clock period

	logic tick;
	logic slot_end;
	assign tick     = (s.st != cesr_pkg::PG_IDLE) && (s.qcnt == Q_LAST);
	assign slot_end = tick && (s.phase == 2'h3);

	always_comb
	begin
		next_s          = s;
		next_s.wr_take  = 1'b0;
		next_s.rd_valid = 1'b0;
		next_s.done     = 1'b0;
		next_s.en_n     = ~prog_mode; // holds the FPGA in reset too
		if (s.st != cesr_pkg::PG_IDLE)
		begin
			next_s.qcnt = tick ? 16'h0000 : s.qcnt + 16'h0001;
			if (tick)
				next_s.phase = s.phase + 2'h1;
		end
		case (s.st)
			cesr_pkg::PG_IDLE:
			begin
				if (req_valid && prog_mode && !s.en_n)
				begin
					next_s.st       = cesr_pkg::PG_START;
					next_s.step     = cesr_pkg::P_DEVW; // address load first
					next_s.write_op = req_write;
					next_s.addr     = req_addr;
					next_s.remain   = req_len;
					next_s.phase    = 2'h0;
					next_s.qcnt     = 16'h0000;
					next_s.nack     = 1'b0;
				end
			end
			cesr_pkg::PG_START:
			begin
				if (slot_end)
				begin
					next_s.st   = cesr_pkg::PG_BYTE;
					next_s.tx   = 1'b1;
					next_s.bitn = 4'h0;
					next_s.sh   = (s.step == cesr_pkg::P_DEVR) ?
						(cesr_pkg::DEV_SELECT | cesr_pkg::RW_READ) : cesr_pkg::DEV_SELECT;
				end
			end
			cesr_pkg::PG_BYTE:
			begin
				if (slot_end && s.bitn != cesr_pkg::SLOT_ACK)
				begin
					next_s.bitn = s.bitn + 4'h1;
					next_s.sh   = s.tx ? {s.sh[6:0], 1'b0} : {sda, s.sh[7:1]};
					if (!s.tx && s.bitn == cesr_pkg::SLOT_LAST_BIT)
					begin
						next_s.rd_data  = {sda, s.sh[7:1]}; // data arrives LSB first
						next_s.rd_valid = 1'b1;
						next_s.remain   = s.remain - LEN_W'(1);
						next_s.rx_ack   = (s.remain != LEN_W'(1)); // nack the last
					end
				end
				else if (slot_end && !s.tx)
				begin
					next_s.bitn = 4'h0;
					if (s.remain == '0)
						next_s.st = cesr_pkg::PG_STOP;
				end
				else if (slot_end && sda)
				begin
					next_s.nack = 1'b1;
					next_s.st   = cesr_pkg::PG_STOP;
				end
				else if (slot_end)
				begin
					next_s.bitn = 4'h0;
					next_s.step = s.step + 3'h1;
					case (s.step)
						cesr_pkg::P_DEVW: next_s.sh = s.addr[23:16];
						cesr_pkg::P_A2:   next_s.sh = s.addr[15:8];
						cesr_pkg::P_A1:   next_s.sh = s.addr[7:0];
						cesr_pkg::P_A0:
						begin
							if (s.write_op)
							begin
								next_s.sh      = rev8(wr_data);
								next_s.wr_take = 1'b1;
							end
							else
							begin
								next_s.st   = cesr_pkg::PG_START; // repeated start
								next_s.step = cesr_pkg::P_DEVR;
							end
						end
						cesr_pkg::P_WDATA:
						begin
							// caller supplies whole pages
							next_s.step   = cesr_pkg::P_WDATA;
							next_s.remain = s.remain - LEN_W'(1);
							if (s.remain == LEN_W'(1))
								next_s.st = cesr_pkg::PG_STOP;
							else
							begin
								next_s.sh      = rev8(wr_data);
								next_s.wr_take = 1'b1;
							end
						end
						default:
						begin
							// any length up to the whole array, for verify
							next_s.step   = cesr_pkg::P_RDATA;
							next_s.tx     = 1'b0;
							next_s.rx_ack = (s.remain != LEN_W'(1));
						end
					endcase
				end
			end
			cesr_pkg::PG_STOP:
			begin
				if (slot_end)
				begin
					next_s.st   = cesr_pkg::PG_IDLE;
					next_s.done = 1'b1;
				end
			end
			default: next_s.st = cesr_pkg::PG_IDLE;
		endcase
		// pin levels follow the next phase
		case (next_s.st)
			cesr_pkg::PG_START:
			begin
				next_s.scl     = (next_s.phase == 2'h1) || (next_s.phase == 2'h2);
				next_s.sda_low = next_s.phase[1];
			end
			cesr_pkg::PG_STOP:
			begin
				next_s.scl     = (next_s.phase != 2'h0);
				next_s.sda_low = ~next_s.phase[1];
			end
			cesr_pkg::PG_BYTE:
			begin
				next_s.scl = next_s.phase[1];
				if (next_s.bitn == cesr_pkg::SLOT_ACK)
					next_s.sda_low = ~next_s.tx & next_s.rx_ack;
				else
					next_s.sda_low = next_s.tx & ~next_s.sh[7];
			end
			default:
			begin
				next_s.scl     = 1'b1;
				next_s.sda_low = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s <= PRG_RST;
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign link.cfg_serial_clock         = s.scl;
	assign link.program_mode_enable_n    = s.en_n;
	assign link.cfg_serial_data_host_out = 1'b0;
	assign link.cfg_serial_data_host_oe  = s.sda_low;
	assign req_ready                     = (s.st == cesr_pkg::PG_IDLE) && prog_mode && !s.en_n;
	assign wr_take                       = s.wr_take;
	assign rd_data                       = s.rd_data;
	assign rd_valid                      = s.rd_valid;
	assign done                          = s.done;
	assign nack                          = s.nack;

endmodule // cesr_programmer

// ### tb/cesr_link_properties.sv
// concurrent checks on the two-wire programming link
`timescale 1ns/1ps
module cesr_link_properties #(
	parameter int QUARTER_CYC = 4
) (
	// system
	input wire logic sys_clk,
	input wire logic rst,
	// link wires and drives
	input wire logic cfg_serial_clock,
	input wire logic program_mode_enable_n,
	input wire logic cfg_serial_data,
	input wire logic cfg_serial_data_dev_out,
	input wire logic cfg_serial_data_dev_oe,
	input wire logic cfg_serial_data_host_out,
	input wire logic cfg_serial_data_host_oe
);
	// margin of two cycles for the registered drive paths
	localparam int FALL_MAX = QUARTER_CYC + 2;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// contention with clock high means the device kept driving into a host slot
	low_drive_a: assert property (
		cfg_serial_data_dev_oe |-> !cfg_serial_data_dev_out
			&& !(cfg_serial_data_host_oe && cfg_serial_clock))
		else $error("device drives high or against the programmer");
	idle_release_a: assert property (
		program_mode_enable_n [*6] |-> !cfg_serial_data_dev_oe)
		else $error("device drives outside programming mode");
	dev_change_low_a: assert property (disable iff (rst || program_mode_enable_n)
		$changed(cfg_serial_data_dev_oe) |-> !cfg_serial_clock)
		else $error("device changed data while clock high");
	start_idle_a: assert property (
		$fell(cfg_serial_data) && cfg_serial_clock |=> !cfg_serial_data_dev_oe [*6])
		else $error("device drives right after start");
	stop_idle_a: assert property (
		$rose(cfg_serial_data) && cfg_serial_clock |=> !cfg_serial_data_dev_oe [*8])
		else $error("device drives right after stop");
	host_start_a: assert property (
		$rose(cfg_serial_data_host_oe) && cfg_serial_clock && $past(cfg_serial_clock)
		|-> ##[1:FALL_MAX] !cfg_serial_clock)
		else $error("no clock fall after start");
	host_stop_a: assert property (
		$fell(cfg_serial_data_host_oe) && cfg_serial_clock && $past(cfg_serial_clock)
		|=> cfg_serial_clock [*3])
		else $error("clock dropped right after stop");
	clock_high_a: assert property (
		$rose(cfg_serial_clock) |=> cfg_serial_clock [*6])
		else $error("link clock high phase too short");
endmodule // cesr_link_properties

// ### tb/tb_config_eeprom_serial_read.sv
// self-checking bench: programmer and memory joined by the link
`timescale 1ns/1ps
module tb_config_eeprom_serial_read;
	localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
	localparam logic [7:0] PART  = 8'h96; // arbitrary value
	logic        sys_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic        prog_mode = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [23:0] req_addr  = 24'h000000;
	logic [17:0] req_len   = 18'h00001;
	logic [7:0]  wcnt      = 8'h00;
	logic [7:0]  wr_data;
	logic        req_ready, wr_take, rd_valid, done, nack, prog_mode_active;
	logic [7:0]  rd_data, boot_first_byte;
	logic [7:0]  rq[$];
	logic [31:0] bits;
	int          failures    = 0;
	int          comparisons = 0;

	cesr_link_if cesr_link_if_i ();
	cesr_device #(.MEM_BYTES(128), .MAKER_CODE(MAKER), .PART_CODE(PART)) cesr_device_i (
		.sys_clk(sys_clk), .rst(rst), .link(cesr_link_if_i.device),
		.boot_first_byte(boot_first_byte), .prog_mode_active(prog_mode_active));
	// quarter of 8 keeps the start low phase above the device reaction time
	cesr_programmer #(.QUARTER_CYC(8), .LEN_W(18)) cesr_programmer_i (
		.sys_clk(sys_clk), .rst(rst), .link(cesr_link_if_i.programmer),
		.prog_mode(prog_mode), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_addr(req_addr), .req_len(req_len),
		.wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
		.done(done), .nack(nack));
	cesr_link_properties #(.QUARTER_CYC(8)) cesr_link_properties_i (
		.sys_clk(sys_clk), .rst(rst),
		.cfg_serial_clock(cesr_link_if_i.cfg_serial_clock),
		.program_mode_enable_n(cesr_link_if_i.program_mode_enable_n),
		.cfg_serial_data(cesr_link_if_i.cfg_serial_data),
		.cfg_serial_data_dev_out(cesr_link_if_i.cfg_serial_data_dev_out),
		.cfg_serial_data_dev_oe(cesr_link_if_i.cfg_serial_data_dev_oe),
		.cfg_serial_data_host_out(cesr_link_if_i.cfg_serial_data_host_out),
		.cfg_serial_data_host_oe(cesr_link_if_i.cfg_serial_data_host_oe));

	always #12.5 sys_clk = ~sys_clk;
	assign wr_data = (req_addr[7:0] + wcnt) ^ 8'h5C;
	// byte counter and read queue restart when a request is taken
	always @(posedge sys_clk)
	begin
		if (req_valid && req_ready)
		begin
			wcnt <= 8'h00;
			rq.delete();
		end
		else if (wr_take)
			wcnt <= wcnt + 8'h01;
		if (rd_valid) rq.push_back(rd_data);
	end
	// wire history, one bit per rising link clock, newest in bit 0
	always @(posedge cesr_link_if_i.cfg_serial_clock)
		bits <= {bits[30:0], cesr_link_if_i.cfg_serial_data};

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("failures %0d, comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// request held until accepted, address held until done so wr_data stays valid
	task automatic xfer(input logic w, input logic [23:0] a, input logic [17:0] n);
		int t;
		t = 0;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr  <= a;
		req_len   <= n;
		do @(negedge sys_clk); while (req_ready !== 1'b1 && ++t < 200);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		for (t = 0; t < 40000 && done !== 1'b1; t++) @(negedge sys_clk);
		// a frame that never ends counts as a mismatch
		if (done !== 1'b1)
			failures++;
		check("nack", {7'h00, nack}, 8'h00);
	endtask

	// last data byte of a frame as it crossed the wire, first bit in bit 0
	function automatic logic [7:0] wire_byte();
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = bits[9 - i];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst       <= 1'b0;
		prog_mode <= 1'b1;
		xfer(1'b1, 24'h000000, 18'h00080);
		check("boot copy", boot_first_byte, 8'hXX);
		xfer(1'b0, 24'h000010, 18'h00001);
		check("single byte", rq[0], 8'h10 ^ 8'h5C);
		check("address byte", bits[28:21], 8'h10);
		check("address ack", {7'h00, bits[20]}, 8'h00);
		check("read select", bits[18:11], cesr_pkg::DEV_SELECT | cesr_pkg::RW_READ);
		check("wire data", wire_byte(), 8'h10 ^ 8'h5C);
		check("final nack", {7'h00, bits[1]}, 8'h01);
		xfer(1'b0, 24'h00007E, 18'h00004);
		check("byte count", 8'(rq.size()), 8'h04);
		for (int i = 0; i < 4; i++) check("seq byte", rq[i], ((8'h7E + 8'(i)) & 8'h7F) ^ 8'h5C);
		xfer(1'b0, cesr_pkg::ID_ADDR, 18'h00002);
		check("maker code", rq[0], MAKER);
		check("part code", rq[1], PART);
		check("part code wire", wire_byte(), PART);
		@(posedge sys_clk);
		prog_mode <= 1'b0;
		repeat (8) @(negedge sys_clk);
		check("mode off", {7'h00, prog_mode_active}, 8'h00);
		check("ready off", {7'h00, req_ready}, 8'h00);
		// reset stands in for a power cycle of the memory
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst       <= 1'b0;
		prog_mode <= 1'b1;
		repeat (8) @(negedge sys_clk);
		check("boot after cycle", boot_first_byte, 8'h00 ^ 8'h5C);
		check("mode on", {7'h00, prog_mode_active}, 8'h01);
		complete_run();
	end

	initial
	begin
		#2000000;
		failures++;
		complete_run();
	end
endmodule // tb_config_eeprom_serial_read
